// ===== ajb_angle_jump_stage.sv
`timescale 1ns/1ps
// Overview of operation
// - Sample block input at each cycle start
// - Unblocked pick-up drives trip or alarm
// - Blocked pick-up only raises blocked indication
// - Condition reads normal, blocked, trip, alarm
// - Validity flag for monitored channel selection
// - Report per-channel 20 ms angle change
// - Report per-channel voltage to limit ratio
// - Time-stamped events on six state edges
// - Event selection: on, off or both
// - Clearable alarm, trip, blocked counters
// - Fault record on each cycle with an on edge
// - Record holds time, code, channel, angles, group
// - Trip holds 20 ms then self clears
// - Undervoltage below limit means blocked
module ajb_angle_jump_stage #(
  parameter int unsigned TRIP_HOLD = ajb_pkg::TRIP_HOLD_CYC,
  parameter int unsigned TSW       = 48,
  parameter int unsigned AW        = 16,
  parameter int unsigned UW        = 16,
  parameter int unsigned CW        = 16
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // Program cycle and pick-up stage
  input  wire logic                 cycle_start,
  input  wire logic                 block_in,
  input  wire logic                 trip_pickup,
  input  wire logic                 alarm_pickup,
  input  wire logic [1:0]           fault_chan,
  input  wire logic                 chan_sel_ok,
  input  wire logic [2:0]           setting_group,
  input  wire logic [TSW-1:0]       timestamp,
  // Measurements, three channels packed
  input  wire logic [3*AW-1:0]      angle_diff_in,
  input  wire logic [3*AW-1:0]      trip_angle_in,
  input  wire logic [3*AW-1:0]      alarm_angle_in,
  input  wire logic [3*UW-1:0]      volt_ratio_in,
  // Configuration and commands
  input  wire logic [1:0]           event_select,
  input  wire logic                 counters_clear,
  input  wire logic [3:0]           rec_index,
  // Stage outputs
  output logic                      trip_out,
  output logic                      alarm_out,
  output logic                      blocked_out,
  output logic [1:0]                condition,
  output logic                      sel_valid,
  output logic [3*AW-1:0]           angle_diff,
  output logic [3*UW-1:0]           volt_ratio,
  // Event output
  output logic                      event_valid,
  output logic [2:0]                event_code,
  output logic [TSW-1:0]            event_time,
  // Counters
  output logic [CW-1:0]             alarm_count,
  output logic [CW-1:0]             trip_count,
  output logic [CW-1:0]             block_count,
  // Fault record read port
  output logic [3:0]                rec_count,
  output logic [TSW-1:0]            rec_time,
  output logic [2:0]                rec_code,
  output logic [1:0]                rec_chan,
  output logic [AW-1:0]             rec_trip_angle,
  output logic [AW-1:0]             rec_alarm_angle,
  output logic [2:0]                rec_group
);
  localparam int unsigned RD = ajb_pkg::REC_DEPTH;
  localparam int unsigned HW = $clog2(TRIP_HOLD + 1);

  // Block level captured once per program cycle
  logic          block_reg;
  logic [HW-1:0] hold_reg;
  logic          prev_trip_reg, prev_alarm_reg, prev_block_reg;

  // Undervoltage: ratio below 1.00 p.u. counts as blocked
  localparam logic [UW-1:0] ONE_PU = UW'(100);
  wire under_v = (volt_ratio_in[UW-1:0] < ONE_PU) ||
                 (volt_ratio_in[2*UW-1:UW] < ONE_PU) ||
                 (volt_ratio_in[3*UW-1:2*UW] < ONE_PU);
  wire blk_now   = cycle_start ? block_in : block_reg;
  wire blocked   = blk_now || under_v;
  wire any_pick  = trip_pickup || alarm_pickup;
  wire trip_go   = trip_pickup && !blocked;
  wire alarm_go  = alarm_pickup && !blocked;
  wire block_go  = any_pick && blocked;
  wire trip_on   = trip_go && !trip_out;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      block_reg <= 1'b0;
    end else if (cycle_start) begin
      block_reg <= block_in;
    end
  end

  // Trip pulse: fixed length, no acknowledge needed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_reg <= '0;
      trip_out <= 1'b0;
    end else if (trip_on) begin
      hold_reg <= HW'(TRIP_HOLD - 1);
      trip_out <= 1'b1;
    end else if (hold_reg != '0) begin
      hold_reg <= hold_reg - HW'(1);
    end else begin
      trip_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarm_out   <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      alarm_out   <= alarm_go;
      blocked_out <= block_go;
    end
  end

  wire [1:0] cond_next = trip_out    ? ajb_pkg::COND_TRIP :
                         alarm_out   ? ajb_pkg::COND_ALARM :
                         blocked_out ? ajb_pkg::COND_BLOCKED :
                                       ajb_pkg::COND_NORMAL;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      condition  <= ajb_pkg::COND_NORMAL;
      sel_valid  <= 1'b0;
      angle_diff <= '0;
      volt_ratio <= '0;
    end else begin
      condition  <= cond_next;
      sel_valid  <= chan_sel_ok;
      angle_diff <= angle_diff_in;
      volt_ratio <= volt_ratio_in;
    end
  end

  // Edge detection on the three stage outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_trip_reg  <= 1'b0;
      prev_alarm_reg <= 1'b0;
      prev_block_reg <= 1'b0;
    end else begin
      prev_trip_reg  <= trip_out;
      prev_alarm_reg <= alarm_out;
      prev_block_reg <= blocked_out;
    end
  end

  wire [2:0] cur  = {alarm_out, trip_out, blocked_out};
  wire [2:0] prv  = {prev_alarm_reg, prev_trip_reg, prev_block_reg};
  wire [2:0] rise = cur & ~prv;
  wire [2:0] fall = ~cur & prv;
  // One edge per cycle reported; priority blocked, trip, alarm
  wire [2:0] ev_code =
    rise[0] ? ajb_pkg::EV_BLOCK_ON  : fall[0] ? ajb_pkg::EV_BLOCK_OFF :
    rise[1] ? ajb_pkg::EV_TRIP_ON   : fall[1] ? ajb_pkg::EV_TRIP_OFF  :
    rise[2] ? ajb_pkg::EV_ALARM_ON  : ajb_pkg::EV_ALARM_OFF;
  wire ev_any   = |(rise | fall);
  wire ev_is_on = !ev_code[0];
  wire ev_pass  = ev_any &&
    ((event_select == ajb_pkg::EVSEL_BOTH) ||
     (event_select == ajb_pkg::EVSEL_ON  &&  ev_is_on) ||
     (event_select == ajb_pkg::EVSEL_OFF && !ev_is_on));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      event_valid <= 1'b0;
      event_code  <= ajb_pkg::EV_BLOCK_ON;
      event_time  <= '0;
    end else begin
      event_valid <= ev_pass;
      event_code  <= ev_code;
      event_time  <= timestamp;
    end
  end

  // Counters: clear zeroes a count, or restarts it at one when an on edge comes in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarm_count <= '0;
      trip_count  <= '0;
      block_count <= '0;
    end else begin
      alarm_count <= rise[2] ? (counters_clear ? CW'(1) : alarm_count + CW'(1))
                             : (counters_clear ? '0 : alarm_count);
      trip_count  <= rise[1] ? (counters_clear ? CW'(1) : trip_count + CW'(1))
                             : (counters_clear ? '0 : trip_count);
      block_count <= rise[0] ? (counters_clear ? CW'(1) : block_count + CW'(1))
                             : (counters_clear ? '0 : block_count);
    end
  end

  // Fault record ring
  logic [TSW-1:0] rt_mem [RD];
  logic [2:0]     rc_mem [RD];
  logic [1:0]     rf_mem [RD];
  logic [AW-1:0]  ra_mem [RD];
  logic [AW-1:0]  rl_mem [RD];
  logic [2:0]     rg_mem [RD];
  logic [3:0]     wr_reg;
  wire            rec_we = |rise;
  // Records keep the on edge even when an off edge takes the event slot
  wire [2:0]      on_code = rise[0] ? ajb_pkg::EV_BLOCK_ON :
                            rise[1] ? ajb_pkg::EV_TRIP_ON  :
                                      ajb_pkg::EV_ALARM_ON;
  wire [AW-1:0]   t_ang  = trip_angle_in[fault_chan[0+:2]*AW +: AW];
  wire [AW-1:0]   a_ang  = alarm_angle_in[fault_chan[0+:2]*AW +: AW];
  wire [3:0]      wr_nx  = (wr_reg == 4'(RD - 1)) ? 4'h0 : wr_reg + 4'h1;
  // Newest record at index 0
  wire [4:0]      rd_sum = {1'b0, wr_reg} + 5'(RD) - 5'h1 - {1'b0, rec_index};
  wire [3:0]      rd_ptr = (rd_sum >= 5'(RD)) ? 4'(rd_sum - 5'(RD))
                                             : rd_sum[3:0];

  always_ff @(posedge clk) begin
    if (rec_we) begin
      rt_mem[wr_reg] <= timestamp;
      rc_mem[wr_reg] <= on_code;
      rf_mem[wr_reg] <= fault_chan;
      ra_mem[wr_reg] <= t_ang;
      rl_mem[wr_reg] <= a_ang;
      rg_mem[wr_reg] <= setting_group;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_reg    <= '0;
      rec_count <= '0;
    end else if (rec_we) begin
      wr_reg    <= wr_nx;
      if (rec_count != 4'(RD)) rec_count <= rec_count + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rec_time        <= '0;
      rec_code        <= '0;
      rec_chan        <= '0;
      rec_trip_angle  <= '0;
      rec_alarm_angle <= '0;
      rec_group       <= '0;
    end else begin
      rec_time        <= rt_mem[rd_ptr];
      rec_code        <= rc_mem[rd_ptr];
      rec_chan        <= rf_mem[rd_ptr];
      rec_trip_angle  <= ra_mem[rd_ptr];
      rec_alarm_angle <= rl_mem[rd_ptr];
      rec_group       <= rg_mem[rd_ptr];
    end
  end

  // Checks
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Trip pulse: a rising edge, then a run of high cycles
  sequence trip_start_s;
    $rose(trip_out);
  endsequence
  sequence trip_stays_s;
    trip_out [*8];
  endsequence
  trip_hold_a: assert property (trip_start_s |=> trip_stays_s)
    else $error("trip released early");
  block_excl_a: assert property (
    block_go |=> blocked_out && !alarm_out)
    else $error("blocked pickup not indicated");
  alarm_go_a: assert property (alarm_go |=> alarm_out)
    else $error("alarm missing");
  event_sel_a: assert property (
    event_valid && $past(event_select) == ajb_pkg::EVSEL_ON
      |-> !event_code[0])
    else $error("off event passed on-only filter");
  rec_grow_a: assert property (
    rec_we && rec_count < 4'(RD) |=> rec_count == $past(rec_count) + 4'h1)
    else $error("record count not advanced");
  rec_wrap_a: assert property (rec_we |=> wr_reg == $past(wr_nx))
    else $error("record pointer wrong");
  cond_trip_a: assert property (
    trip_out |=> condition == ajb_pkg::COND_TRIP)
    else $error("condition not trip");
  ctr_clr_a: assert property (
    counters_clear && !rise[1] |=> trip_count == '0)
    else $error("trip counter not cleared");
endmodule : ajb_angle_jump_stage

// ===== ajb_pkg.sv
package ajb_pkg;
  // Timing at 100 MHz
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TRIP_HOLD_MS  = 20;
  localparam int unsigned TRIP_HOLD_CYC =
    TRIP_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned BLOCK_LEAD_MS = 5;
  localparam int unsigned REC_DEPTH     = 12;

  // Stage condition codes
  localparam logic [1:0] COND_NORMAL  = 2'h0;
  localparam logic [1:0] COND_BLOCKED = 2'h1;
  localparam logic [1:0] COND_TRIP    = 2'h2;
  localparam logic [1:0] COND_ALARM   = 2'h3;

  // Event codes: on edges even, off edges odd
  localparam logic [2:0] EV_BLOCK_ON  = 3'h0;
  localparam logic [2:0] EV_BLOCK_OFF = 3'h1;
  localparam logic [2:0] EV_TRIP_ON   = 3'h2;
  localparam logic [2:0] EV_TRIP_OFF  = 3'h3;
  localparam logic [2:0] EV_ALARM_ON  = 3'h4;
  localparam logic [2:0] EV_ALARM_OFF = 3'h5;

  // Event mask selection
  localparam logic [1:0] EVSEL_ON   = 2'h0;
  localparam logic [1:0] EVSEL_OFF  = 2'h1;
  localparam logic [1:0] EVSEL_BOTH = 2'h2;
endpackage : ajb_pkg

// ===== ajb_cycle_model.sv
`timescale 1ns/1ps
module ajb_cycle_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Program cycle
  output logic            cycle_start,
  // Event logger tap
  input  wire logic       event_valid,
  input  wire logic [2:0]  event_code,
  input  wire logic [47:0] event_time,
  output logic [7:0]       ev_seen,
  output logic [2:0]       ev_last,
  output logic [47:0]      ev_stamp
);
  logic [1:0] phase_reg;

  // Short four-clock program cycle keeps the run brief
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg   <= 2'h0;
      cycle_start <= 1'h0;
    end else begin
      phase_reg   <= phase_reg + 2'h1;
      cycle_start <= (phase_reg == 2'h3);
    end
  end

  // Logger keeps a running count and the latest code and stamp only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_seen  <= 8'h00;
      ev_last  <= 3'h7;
      ev_stamp <= 48'h0000_0000_0000;
    end else if (event_valid) begin
      ev_seen  <= ev_seen + 8'h01;
      ev_last  <= event_code;
      ev_stamp <= event_time;
    end
  end
endmodule : ajb_cycle_model

// ===== ajb_angle_jump_stage_tb.sv
`timescale 1ns/1ps
module ajb_angle_jump_stage_tb;
  localparam int unsigned HOLD = 20;
  logic        clk, resetn, block_in, trip_pickup, alarm_pickup;
  logic        chan_sel_ok, counters_clear, cycle_start, trip_out;
  logic        alarm_out, blocked_out, sel_valid, event_valid;
  logic [1:0]  fault_chan, event_select, condition, rec_chan;
  logic [2:0]  setting_group, event_code, rec_code, rec_group, ev_last;
  logic [3:0]  rec_index, rec_count;
  logic [7:0]  ev_seen, n0;
  logic [47:0] timestamp, angle_diff_in, trip_angle_in, alarm_angle_in;
  logic [47:0] volt_ratio_in, angle_diff, volt_ratio, event_time, rec_time;
  logic [47:0] ev_stamp;
  logic [15:0] alarm_count, trip_count, block_count;
  logic [15:0] rec_trip_angle, rec_alarm_angle;
  int          fails, cmp_count, cyc;

  ajb_angle_jump_stage #(.TRIP_HOLD(HOLD)) uut (
    .clk(clk), .resetn(resetn), .cycle_start(cycle_start),
    .block_in(block_in), .trip_pickup(trip_pickup),
    .alarm_pickup(alarm_pickup), .fault_chan(fault_chan),
    .chan_sel_ok(chan_sel_ok), .setting_group(setting_group),
    .timestamp(timestamp), .angle_diff_in(angle_diff_in),
    .trip_angle_in(trip_angle_in), .alarm_angle_in(alarm_angle_in),
    .volt_ratio_in(volt_ratio_in), .event_select(event_select),
    .counters_clear(counters_clear), .rec_index(rec_index),
    .trip_out(trip_out), .alarm_out(alarm_out),
    .blocked_out(blocked_out), .condition(condition),
    .sel_valid(sel_valid), .angle_diff(angle_diff),
    .volt_ratio(volt_ratio), .event_valid(event_valid),
    .event_code(event_code), .event_time(event_time),
    .alarm_count(alarm_count), .trip_count(trip_count),
    .block_count(block_count), .rec_count(rec_count),
    .rec_time(rec_time), .rec_code(rec_code), .rec_chan(rec_chan),
    .rec_trip_angle(rec_trip_angle), .rec_alarm_angle(rec_alarm_angle),
    .rec_group(rec_group));

  ajb_cycle_model model (
    .clk(clk), .resetn(resetn), .cycle_start(cycle_start),
    .event_valid(event_valid), .event_code(event_code),
    .event_time(event_time), .ev_seen(ev_seen), .ev_last(ev_last),
    .ev_stamp(ev_stamp));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    timestamp <= timestamp + 48'h0000_0000_0001;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Returns on a rising edge: compares see what settled before it, and
  // drives that follow land on that edge as non-blocking assignments
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic t_trip;
    logic [47:0] t0;
    @(posedge clk);
    t0 = timestamp;
    fault_chan <= 2'h1;
    setting_group <= 3'h5;
    trip_pickup <= 1'h1;
    tick(8);
    chk(trip_out, 1'h1);
    chk(condition, ajb_pkg::COND_TRIP);
    chk(ev_last, ajb_pkg::EV_TRIP_ON);
    chk(ev_stamp, t0 + 48'h0000_0000_0002);
    chk(trip_count, 16'h0001);
    chk(rec_code, ajb_pkg::EV_TRIP_ON);
    chk({rec_chan, rec_group}, 5'h0d);
    chk(rec_time, t0 + 48'h0000_0000_0002);
    chk(rec_trip_angle, trip_angle_in[16 +: 16]);
    @(posedge clk);
    trip_pickup <= 1'h0;
    tick(HOLD - 8);
    chk(trip_out, 1'h1);
    tick(1);
    chk(trip_out, 1'h0);
    tick(11);
    chk(ev_last, ajb_pkg::EV_TRIP_OFF);
  endtask : t_trip

  task automatic t_block;
    @(posedge clk);
    block_in <= 1'h1;
    tick(8);
    alarm_pickup <= 1'h1;
    tick(8);
    chk({blocked_out, alarm_out}, 2'h2);
    chk(condition, ajb_pkg::COND_BLOCKED);
    chk(ev_last, ajb_pkg::EV_BLOCK_ON);
    chk(block_count, 16'h0001);
    alarm_pickup <= 1'h0;
    block_in <= 1'h0;
    tick(8);
    alarm_pickup <= 1'h1;
    tick(8);
    chk({blocked_out, alarm_out}, 2'h1);
    chk(condition, ajb_pkg::COND_ALARM);
    chk(alarm_count, 16'h0001);
    alarm_pickup <= 1'h0;
    tick(8);
  endtask : t_block

  task automatic t_under;
    @(posedge clk);
    volt_ratio_in <= 48'h0064_0063_0064;
    chan_sel_ok <= 1'h0;
    alarm_pickup <= 1'h1;
    tick(8);
    chk({blocked_out, alarm_out}, 2'h2);
    chk(volt_ratio, 48'h0064_0063_0064);
    chk(angle_diff, angle_diff_in);
    chk(sel_valid, 1'h0);
    volt_ratio_in <= 48'h0064_0064_0064;
    chan_sel_ok <= 1'h1;
    alarm_pickup <= 1'h0;
    tick(8);
    chk(sel_valid, 1'h1);
    chk(condition, ajb_pkg::COND_NORMAL);
    counters_clear <= 1'h1;
    tick(1);
    counters_clear <= 1'h0;
    tick(2);
    chk({alarm_count, trip_count, block_count}, 48'h0);
  endtask : t_under

  task automatic t_records;
    @(posedge clk);
    event_select <= ajb_pkg::EVSEL_ON;
    fault_chan <= 2'h0;
    n0 = ev_seen;
    for (int i = 0; i < 14; i++) begin
      setting_group <= i[2:0];
      alarm_pickup <= 1'h1;
      tick(6);
      alarm_pickup <= 1'h0;
      tick(6);
    end
    chk(ev_seen - n0, 8'h0e);
    chk(rec_count, 4'hc);
    chk({rec_code, rec_group}, {ajb_pkg::EV_ALARM_ON, 3'h5});
    chk(rec_alarm_angle, alarm_angle_in[15:0]);
    rec_index <= 4'hb;
    event_select <= ajb_pkg::EVSEL_OFF;
    tick(2);
    chk(rec_group, 3'h2);
    n0 = ev_seen;
    alarm_pickup <= 1'h1;
    tick(6);
    alarm_pickup <= 1'h0;
    tick(6);
    chk({ev_seen - n0, ev_last}, {8'h01, ajb_pkg::EV_ALARM_OFF});
  endtask : t_records

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  initial begin
    {block_in, trip_pickup, alarm_pickup, counters_clear} = 4'h0;
    {chan_sel_ok, fault_chan, setting_group, rec_index} = 10'h200;
    event_select = ajb_pkg::EVSEL_BOTH;
    timestamp = 48'h0;
    angle_diff_in = 48'h0300_0200_0100;
    trip_angle_in = 48'h0003_0002_0001;
    alarm_angle_in = 48'h0030_0020_0010;
    volt_ratio_in = 48'h0064_0064_0064;
    {fails, cmp_count, cyc} = 96'h0;
    resetn = 1'h0;
    repeat (6) @(posedge clk);
    resetn <= 1'h1;
    t_trip();
    t_block();
    t_under();
    t_records();
    end_of_test();
  end
endmodule : ajb_angle_jump_stage_tb
